/* cdp_map.vh */
`ifndef CDP_MAP_VH
`define CDP_MAP_VH
// Register byte offsets
`define CDP_OFF_HSR 8'h00
`define CDP_OFF_LSR 8'h04
`define CDP_OFF_ACC 8'h08
`define CDP_OFF_DSL 8'h0C
`define CDP_OFF_OP 8'h10
`define CDP_OFF_RES 8'h14
`define CDP_OFF_IOC 8'h18
`define CDP_OFF_STK 8'h1C
`define CDP_OFF_FPTR 8'h20
`define CDP_OFF_AUXSEL 8'h24
`define CDP_OFF_AUXDAT 8'h28
// High status register bits
`define CDP_HSR_CARRY 0
`define CDP_HSR_SLICE 4
`define CDP_HSR_HALT 5
`define CDP_HSR_PERR 6
`define CDP_HSR_TRAPEN 7
`define CDP_HSR_RST 8'h00
// Operation word fields
`define CDP_OP_FN_LO 0
`define CDP_OP_A_LO 4
`define CDP_OP_B_LO 8
`define CDP_OP_D_LO 12
`define CDP_OP_IMM_LO 16
// Operand and destination codes, 0..7 are scratch registers
`define CDP_SRC_HSR 4'h8
`define CDP_SRC_LSR 4'h9
`define CDP_SRC_ACC 4'hA
`define CDP_SRC_DUMMY 4'hB
`define CDP_SRC_IMM 4'hC
// ALU functions
`define CDP_FN_ADD 4'h0
`define CDP_FN_ADC 4'h1
`define CDP_FN_SUB 4'h2
`define CDP_FN_AND 4'h3
`define CDP_FN_OR 4'h4
`define CDP_FN_XOR 4'h5
`define CDP_FN_DADD 4'h6
`define CDP_FN_MULL 4'h7
`define CDP_FN_MULH 4'h8
`define CDP_FN_SHHH 4'h9
`define CDP_FN_SHLL 4'hA
`define CDP_FN_SHHL 4'hB
`define CDP_FN_SHLH 4'hC
`define CDP_FN_PASSA 4'hD
// I/O control word bits
`define CDP_IOC_DSS 0
`define CDP_IOC_OBS 1
`define CDP_IOC_IRS 2
`define CDP_IOC_DSL_LD 3
`define CDP_IOC_SRC_LO 4
`define CDP_ACC_SRC_IN 2'h1
`define CDP_ACC_SRC_C 2'h2
`define CDP_ACC_SRC_CM 2'h3
// Stack control bits and storage layout
`define CDP_STK_CALL 0
`define CDP_STK_RET 1
`define CDP_STK_DEPTH 7'h60
`define CDP_AUX_BASE 7'h60
// Timing
`define CDP_SLICE_MS 30
`define CDP_CLK_KHZ 10000
`endif

/* cdp_alu.v */
`timescale 1ns/1ns
`include "cdp_map.vh"
module cdp_alu (
  // Operands
  input wire [7:0] a_i,
  input wire [7:0] b_i,
  input wire [3:0] fn_i,
  input wire carry_i,
  // Result
  output reg [7:0] c_o,
  output reg carry_o,
  output reg carry_we_o
);
  reg [8:0] sum;
  reg [8:0] rem;
  reg [8:0] tens;
  reg [8:0] ones;
  always @* begin
    sum = {1'b0, a_i} + {1'b0, b_i};
    rem = sum % 9'h064;
    tens = rem / 9'h00A;
    ones = rem % 9'h00A;
    c_o = 8'h00;
    carry_o = 1'b0;
    carry_we_o = 1'b1;
    case (fn_i)
      `CDP_FN_ADD: {carry_o, c_o} = sum;
      `CDP_FN_ADC: {carry_o, c_o} = sum + {8'h00, carry_i};
      `CDP_FN_SUB: {carry_o, c_o} = {1'b0, a_i} - {1'b0, b_i};
      // Binary sum first, then adjusted to two BCD digits
      `CDP_FN_DADD: begin
        c_o = {tens[3:0], ones[3:0]};
        carry_o = (sum >= 9'h064);
      end
      default: begin
        carry_we_o = 1'b0;
        case (fn_i)
          `CDP_FN_AND: c_o = a_i & b_i;
          `CDP_FN_OR: c_o = a_i | b_i;
          `CDP_FN_XOR: c_o = a_i ^ b_i;
          `CDP_FN_MULL: c_o = a_i[3:0] * b_i[3:0];
          `CDP_FN_MULH: c_o = a_i[7:4] * b_i[7:4];
          `CDP_FN_SHHH: c_o = {a_i[7:4], b_i[7:4]};
          `CDP_FN_SHLL: c_o = {a_i[3:0], b_i[3:0]};
          `CDP_FN_SHHL: c_o = {a_i[7:4], b_i[3:0]};
          `CDP_FN_SHLH: c_o = {a_i[3:0], b_i[7:4]};
          `CDP_FN_PASSA: c_o = a_i;
          default: c_o = 8'h00;
        endcase
      end
    endcase
  end
endmodule

/* cdp_datapath.v */
// How it works
// - Halt key press sets high status bit 5 for software polling.
// - High status bit 0 holds the carry of the last carry-producing op.
// - Every 30 ms the slice timer sets high status bit 4.
// - Bit 7 set and parity error bit 6 set raise parity trap request.
// - Low status is eight bits, changed only by software or ALU results.
// - Accumulator loads from input bus, C bus or control memory.
// - Accumulator is input bus, drives output bus, feeds select latch.
// - Accumulator carries the top eight control memory word bits.
// - Eight-bit select latch holds the address on the I/O address bus.
// - Dummy register reads zero and discards anything written.
// - Eight 8-bit scratch registers serve as sources and destinations.
// - Binary ALU combines A and B buses, result via C register.
// - Decimal add sums A and B then converts to BCD.
// - Multiply/shift unit multiplies nibbles or combines A/B nibbles.
// - An immediate constant can enter the ALU on the A bus.
// - Call pushes fetch pointer plus one; return pops it, LIFO.
// - 256x8 RAM holds 96 stack and 32 auxiliary 16-bit entries.
// - Auxiliary register chosen by a five-bit select field.
// - Second byte of each entry sits 128 above its base address.
// - Select strobe shows latched address; outbound strobe sends data.
// - Input request strobe asks the peripheral for inbound data.
`timescale 1ns/1ns
`include "cdp_map.vh"
module cdp_datapath #(
  parameter SLICE_CYCLES = `CDP_SLICE_MS * `CDP_CLK_KHZ
) (
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // Wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  // Operator and memory status pins
  input wire halt_key_i,
  input wire data_parity_error_flag_i,
  output reg parity_trap_request_o,
  // Control memory high byte
  input wire [7:0] cm_rdata_hi_i,
  output reg [7:0] cm_wdata_hi_o,
  // I/O bus
  output reg [7:0] io_addr_o,
  output reg [7:0] io_out_data_o,
  output reg device_select_strobe_o,
  output reg outbound_data_strobe_o,
  output reg input_request_strobe_o,
  input wire [7:0] io_in_data_i,
  input wire inbound_data_strobe_i
);
  localparam ST_IDLE = 4'b0001;
  localparam ST_LO = 4'b0010;
  localparam ST_HI = 4'b0100;
  localparam ST_ACK = 4'b1000;
  localparam K_PUSH = 2'd0;
  localparam K_POP = 2'd1;
  localparam K_AUXW = 2'd2;
  localparam K_AUXR = 2'd3;

  reg [7:0] hsr_q;
  reg [7:0] lsr_q;
  reg [7:0] acc_q;
  reg [7:0] dsl_q;
  reg [7:0] c_q;
  reg [7:0] file_q [0:7];
  reg [7:0] ram [0:255];
  reg [15:0] fptr_q;
  reg [6:0] sp_q;
  reg [4:0] auxsel_q;
  reg [15:0] auxrd_q;
  reg [15:0] wdat_q;
  reg [6:0] base_q;
  reg [1:0] kind_q;
  reg [7:0] tmp_lo_q;
  reg [3:0] st_q;
  reg stk_err_q;
  reg [18:0] slice_cnt_q;
  reg slice_tick_q;
  reg halt_s1_q, halt_s2_q;
  reg perr_s1_q, perr_s2_q;
  reg ibs_s1_q, ibs_s2_q, ibs_s3_q;
  reg [7:0] ind_s1_q, ind_s2_q;
  reg [7:0] in_q;

  // Bus request decode
  wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o & (st_q == ST_IDLE);
  wire wr = req & wb_we_i & wb_sel_i[0];
  wire [31:0] ioc = wb_dat_i;
  wire wr_hsr = wr & (wb_adr_i == `CDP_OFF_HSR);
  wire wr_lsr = wr & (wb_adr_i == `CDP_OFF_LSR);
  wire wr_acc = wr & (wb_adr_i == `CDP_OFF_ACC);
  wire wr_dsl = wr & (wb_adr_i == `CDP_OFF_DSL);
  wire wr_op = wr & (wb_adr_i == `CDP_OFF_OP);
  wire wr_ioc = wr & (wb_adr_i == `CDP_OFF_IOC);
  wire wr_stk = wr & (wb_adr_i == `CDP_OFF_STK);
  wire wr_fptr = req & wb_we_i & (wb_adr_i == `CDP_OFF_FPTR);
  wire wr_auxsel = wr & (wb_adr_i == `CDP_OFF_AUXSEL);
  wire wr_auxdat = wr & (wb_adr_i == `CDP_OFF_AUXDAT);
  wire rd_auxdat = req & ~wb_we_i & (wb_adr_i == `CDP_OFF_AUXDAT);
  wire do_call = wr_stk & ioc[`CDP_STK_CALL];
  wire do_ret = wr_stk & ~ioc[`CDP_STK_CALL] & ioc[`CDP_STK_RET];
  wire call_ok = do_call & (sp_q != `CDP_STK_DEPTH);
  wire ret_ok = do_ret & (sp_q != 7'h00);

  // Operation fields
  wire [3:0] op_fn = wb_dat_i[`CDP_OP_FN_LO +: 4];
  wire [3:0] op_a = wb_dat_i[`CDP_OP_A_LO +: 4];
  wire [3:0] op_b = wb_dat_i[`CDP_OP_B_LO +: 4];
  wire [3:0] op_d = wb_dat_i[`CDP_OP_D_LO +: 4];
  wire [7:0] op_imm = wb_dat_i[`CDP_OP_IMM_LO +: 8];

  function [7:0] src_val;
    input [3:0] sel;
    input [7:0] imm;
    input allow_imm;
    begin
      if (!sel[3])
        src_val = file_q[sel[2:0]];
      else if (sel == `CDP_SRC_HSR)
        src_val = hsr_q;
      else if (sel == `CDP_SRC_LSR)
        src_val = lsr_q;
      else if (sel == `CDP_SRC_ACC)
        src_val = acc_q;
      else if (sel == `CDP_SRC_IMM && allow_imm)
        src_val = imm;
      else
        src_val = 8'h00;
    end
  endfunction

  wire [7:0] a_bus = src_val(op_a, op_imm, 1'b1);
  wire [7:0] b_bus = src_val(op_b, op_imm, 1'b0);
  wire [7:0] alu_c;
  wire alu_carry;
  wire alu_carry_we;

  cdp_alu u_alu (
    .a_i(a_bus),
    .b_i(b_bus),
    .fn_i(op_fn),
    .carry_i(hsr_q[`CDP_HSR_CARRY]),
    .c_o(alu_c),
    .carry_o(alu_carry),
    .carry_we_o(alu_carry_we)
  );

  // Results land through the C register as well as the chosen destination
  always @(posedge clk_i) begin
    if (rst_i)
      c_q <= 8'h00;
    else if (wr_op)
      c_q <= alu_c;
  end

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_file
      always @(posedge clk_i) begin
        if (rst_i)
          file_q[gi] <= 8'h00;
        else if (wr_op && op_d == gi)
          file_q[gi] <= alu_c;
      end
    end
  endgenerate

  // Pin synchronisers; the first stage feeds only the second
  always @(posedge clk_i) begin
    if (rst_i) begin
      halt_s1_q <= 1'b0;
      halt_s2_q <= 1'b0;
      perr_s1_q <= 1'b0;
      perr_s2_q <= 1'b0;
      ibs_s1_q <= 1'b0;
      ibs_s2_q <= 1'b0;
      ibs_s3_q <= 1'b0;
      ind_s1_q <= 8'h00;
      ind_s2_q <= 8'h00;
    end else begin
      halt_s1_q <= halt_key_i;
      halt_s2_q <= halt_s1_q;
      perr_s1_q <= data_parity_error_flag_i;
      perr_s2_q <= perr_s1_q;
      ibs_s1_q <= inbound_data_strobe_i;
      ibs_s2_q <= ibs_s1_q;
      ibs_s3_q <= ibs_s2_q;
      ind_s1_q <= io_in_data_i;
      ind_s2_q <= ind_s1_q;
    end
  end

  // Peripheral data is held stable around its strobe, so the synced copy
  // is valid when the synced rising edge appears
  wire ibs_rise = ibs_s2_q & ~ibs_s3_q;

  // Time slice divider
  always @(posedge clk_i) begin
    if (rst_i) begin
      slice_cnt_q <= 19'h0_0000;
      slice_tick_q <= 1'b0;
    end else if (slice_cnt_q == SLICE_CYCLES - 1) begin
      slice_cnt_q <= 19'h0_0000;
      slice_tick_q <= 1'b1;
    end else begin
      slice_cnt_q <= slice_cnt_q + 19'h0_0001;
      slice_tick_q <= 1'b0;
    end
  end

  // High status: software or ALU value first, hardware sets win over it
  reg [7:0] hsr_d;
  always @* begin
    hsr_d = hsr_q;
    if (wr_hsr)
      hsr_d = wb_dat_i[7:0];
    if (wr_op && op_d == `CDP_SRC_HSR)
      hsr_d = alu_c;
    if (wr_op && alu_carry_we)
      hsr_d[`CDP_HSR_CARRY] = alu_carry;
    if (slice_tick_q)
      hsr_d[`CDP_HSR_SLICE] = 1'b1;
    if (halt_s2_q)
      hsr_d[`CDP_HSR_HALT] = 1'b1;
    if (perr_s2_q)
      hsr_d[`CDP_HSR_PERR] = 1'b1;
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      hsr_q <= `CDP_HSR_RST;
      lsr_q <= 8'h00;
      parity_trap_request_o <= 1'b0;
    end else begin
      hsr_q <= hsr_d;
      if (wr_lsr)
        lsr_q <= wb_dat_i[7:0];
      else if (wr_op && op_d == `CDP_SRC_LSR)
        lsr_q <= alu_c;
      parity_trap_request_o <= hsr_q[`CDP_HSR_TRAPEN] &
        hsr_q[`CDP_HSR_PERR];
    end
  end

  // Accumulator, select latch and I/O strobes
  wire [1:0] acc_src = ioc[`CDP_IOC_SRC_LO +: 2];
  always @(posedge clk_i) begin
    if (rst_i) begin
      acc_q <= 8'h00;
      dsl_q <= 8'h00;
      in_q <= 8'h00;
      io_addr_o <= 8'h00;
      io_out_data_o <= 8'h00;
      cm_wdata_hi_o <= 8'h00;
      device_select_strobe_o <= 1'b0;
      outbound_data_strobe_o <= 1'b0;
      input_request_strobe_o <= 1'b0;
    end else begin
      device_select_strobe_o <= wr_ioc & ioc[`CDP_IOC_DSS];
      outbound_data_strobe_o <= wr_ioc & ioc[`CDP_IOC_OBS];
      input_request_strobe_o <= wr_ioc & ioc[`CDP_IOC_IRS];
      if (ibs_rise)
        in_q <= ind_s2_q;
      // Inbound strobe wins over any software load in the same cycle
      if (ibs_rise)
        acc_q <= ind_s2_q;
      else if (wr_acc)
        acc_q <= wb_dat_i[7:0];
      else if (wr_op && op_d == `CDP_SRC_ACC)
        acc_q <= alu_c;
      else if (wr_ioc && acc_src == `CDP_ACC_SRC_IN)
        acc_q <= in_q;
      else if (wr_ioc && acc_src == `CDP_ACC_SRC_C)
        acc_q <= c_q;
      else if (wr_ioc && acc_src == `CDP_ACC_SRC_CM)
        acc_q <= cm_rdata_hi_i;
      if (wr_dsl)
        dsl_q <= wb_dat_i[7:0];
      else if (wr_ioc && ioc[`CDP_IOC_DSL_LD])
        dsl_q <= acc_q;
      // Address bus only changes on the select strobe
      if (wr_ioc && ioc[`CDP_IOC_DSS])
        io_addr_o <= dsl_q;
      io_out_data_o <= acc_q;
      cm_wdata_hi_o <= acc_q;
    end
  end

  // Stack and auxiliary storage sequencer: low byte, then high byte
  wire [7:0] ram_addr = {st_q == ST_HI, base_q};
  wire ram_wr = (st_q == ST_LO || st_q == ST_HI) &&
    (kind_q == K_PUSH || kind_q == K_AUXW);
  wire [7:0] ram_wbyte = (st_q == ST_HI) ? wdat_q[15:8] : wdat_q[7:0];

  always @(posedge clk_i) begin
    if (ram_wr)
      ram[ram_addr] <= ram_wbyte;
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      st_q <= ST_IDLE;
      sp_q <= 7'h00;
      fptr_q <= 16'h0000;
      auxsel_q <= 5'h00;
      auxrd_q <= 16'h0000;
      wdat_q <= 16'h0000;
      base_q <= 7'h00;
      kind_q <= K_PUSH;
      tmp_lo_q <= 8'h00;
      stk_err_q <= 1'b0;
    end else begin
      if (wr_fptr && wb_sel_i[0])
        fptr_q[7:0] <= wb_dat_i[7:0];
      if (wr_fptr && wb_sel_i[1])
        fptr_q[15:8] <= wb_dat_i[15:8];
      if (wr_auxsel)
        auxsel_q <= wb_dat_i[4:0];
      case (st_q)
        ST_IDLE: begin
          if (do_call || do_ret)
            stk_err_q <= ~(call_ok | ret_ok);
          if (call_ok) begin
            kind_q <= K_PUSH;
            base_q <= sp_q;
            wdat_q <= fptr_q + 16'h0001;
            fptr_q <= wb_dat_i[31:16];
            sp_q <= sp_q + 7'h01;
            st_q <= ST_LO;
          end else if (ret_ok) begin
            kind_q <= K_POP;
            base_q <= sp_q - 7'h01;
            sp_q <= sp_q - 7'h01;
            st_q <= ST_LO;
          end else if (wr_auxdat || rd_auxdat) begin
            kind_q <= wr_auxdat ? K_AUXW : K_AUXR;
            base_q <= `CDP_AUX_BASE + {2'b00, auxsel_q};
            wdat_q <= wb_dat_i[15:0];
            st_q <= ST_LO;
          end
        end
        ST_LO: begin
          tmp_lo_q <= ram[ram_addr];
          st_q <= ST_HI;
        end
        ST_HI: begin
          if (kind_q == K_POP)
            fptr_q <= {ram[ram_addr], tmp_lo_q};
          if (kind_q == K_AUXR)
            auxrd_q <= {ram[ram_addr], tmp_lo_q};
          st_q <= ST_ACK;
        end
        ST_ACK: st_q <= ST_IDLE;
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  // Read mux
  reg [31:0] rd_d;
  always @* begin
    case (wb_adr_i)
      `CDP_OFF_HSR: rd_d = {24'h00_0000, hsr_q};
      `CDP_OFF_LSR: rd_d = {24'h00_0000, lsr_q};
      `CDP_OFF_ACC: rd_d = {24'h00_0000, acc_q};
      `CDP_OFF_DSL: rd_d = {24'h00_0000, dsl_q};
      `CDP_OFF_RES: rd_d = {24'h00_0000, c_q};
      `CDP_OFF_IOC: rd_d = {24'h00_0000, in_q};
      `CDP_OFF_STK: rd_d = {16'h0000, stk_err_q, sp_q, 8'h00};
      `CDP_OFF_FPTR: rd_d = {16'h0000, fptr_q};
      `CDP_OFF_AUXSEL: rd_d = {27'h000_0000, auxsel_q};
      `CDP_OFF_AUXDAT: rd_d = {16'h0000, auxrd_q};
      default: rd_d = 32'h0000_0000;
    endcase
  end

  // Ack one cycle after a plain request, or at the end of a RAM sequence
  wire start_seq = call_ok | ret_ok | wr_auxdat | rd_auxdat;
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= (req & ~start_seq) | (st_q == ST_ACK);
      if (st_q == ST_ACK)
        wb_dat_o <= {16'h0000, auxrd_q};
      else if (req && !wb_we_i)
        wb_dat_o <= rd_d;
    end
  end
endmodule

/* cdp_datapath_properties.sv */
`timescale 1ns/1ns
module cdp_datapath_props #(
  parameter SLICE_CYCLES = 300000
) (
  // Clock and reset
  input logic clk_i,
  input logic rst_i,
  // Bus handshake
  input logic wb_cyc_i,
  input logic wb_stb_i,
  input logic wb_ack_o,
  // I/O side
  input logic [7:0] io_addr_o,
  input logic [7:0] io_out_data_o,
  input logic [7:0] cm_wdata_hi_o,
  input logic device_select_strobe_o,
  input logic outbound_data_strobe_o,
  input logic input_request_strobe_o,
  input logic [7:0] io_in_data_i,
  input logic inbound_data_strobe_i
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack stayed high");
  ack_has_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  ack_in_time_a: assert property
    (wb_cyc_i && wb_stb_i && !wb_ack_o |-> ##[1:5] wb_ack_o)
    else $error("request not answered");
  addr_by_select_a: assert property
    ($changed(io_addr_o) |-> device_select_strobe_o)
    else $error("address bus moved without select strobe");
  select_pulse_a: assert property
    (device_select_strobe_o |=> !device_select_strobe_o)
    else $error("select strobe too long");
  outbound_pulse_a: assert property
    (outbound_data_strobe_o |-> wb_ack_o ##1 !outbound_data_strobe_o)
    else $error("outbound strobe malformed");
  request_pulse_a: assert property
    ($rose(input_request_strobe_o) |-> wb_ack_o ##1 !input_request_strobe_o)
    else $error("input request strobe malformed");
  out_mirror_a: assert property (io_out_data_o == cm_wdata_hi_o)
    else $error("output bus and control byte differ");
  inbound_load_a: assert property
    ($rose(inbound_data_strobe_i) ##1 $stable(io_in_data_i)[*5]
     |-> io_out_data_o == io_in_data_i)
    else $error("inbound data not loaded");

  cover property (device_select_strobe_o);
  cover property (outbound_data_strobe_o);
  cover property ($rose(inbound_data_strobe_i));
endmodule

bind cdp_datapath cdp_datapath_props #(.SLICE_CYCLES(SLICE_CYCLES))
  i_cdp_datapath_props (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
  .io_addr_o, .io_out_data_o, .cm_wdata_hi_o, .device_select_strobe_o,
  .outbound_data_strobe_o, .input_request_strobe_o, .io_in_data_i,
  .inbound_data_strobe_i);

/* cdp_periph_model.sv */
`timescale 1ns/1ns
module cdp_periph_model (
  // Clock and reply delay
  input logic clk_i,
  input logic [3:0] wait_i,
  // From the datapath
  input logic [7:0] io_addr_i,
  input logic [7:0] io_out_data_i,
  input logic obs_i,
  input logic irs_i,
  // Replies
  output logic [7:0] io_in_data_o,
  output logic ibs_o,
  output logic [7:0] got_o
);
  initial begin
    io_in_data_o = 8'h00;
    ibs_o = 1'b0;
    got_o = 8'h00;
  end
  always @(posedge clk_i) begin
    if (obs_i)
      got_o <= io_out_data_i;
  end
  // Reply derives from the address, so a stale select shows up at once;
  // the data line turns over after its hold, never keeps the old value
  initial forever begin
    @(posedge clk_i);
    if (irs_i) begin
      repeat (wait_i) @(posedge clk_i);
      io_in_data_o <= io_addr_i ^ 8'h5A;
      ibs_o <= 1'b1;
      repeat (2) @(posedge clk_i);
      ibs_o <= 1'b0;
      repeat (6) @(posedge clk_i);
      io_in_data_o <= ~io_in_data_o;
    end
  end
endmodule

/* tb.sv */
`timescale 1ns/1ns
`include "cdp_map.vh"
module tb;
  logic clk_i;
  logic rst_i;
  logic wb_cyc_i;
  logic wb_stb_i;
  logic wb_we_i;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic halt_key_i;
  logic data_parity_error_flag_i;
  logic parity_trap_request_o;
  logic [7:0] cm_rdata_hi_i;
  logic [7:0] cm_wdata_hi_o;
  logic [7:0] io_addr_o;
  logic [7:0] io_out_data_o;
  logic device_select_strobe_o;
  logic outbound_data_strobe_o;
  logic input_request_strobe_o;
  logic [7:0] io_in_data_i;
  logic inbound_data_strobe_i;
  logic [7:0] got;
  logic [3:0] model_wait;
  logic [31:0] rdat;
  logic [28:0] r;
  int errors;
  int check_count;
  int n;
  // fn, a, b, result, carry
  logic [28:0] rows [0:13] = '{
    {4'h0, 8'hF0, 8'h20, 8'h10, 1'b1}, {4'h1, 8'h01, 8'h01, 8'h03, 1'b0},
    {4'h2, 8'h10, 8'h20, 8'hF0, 1'b1}, {4'h3, 8'h3C, 8'h0F, 8'h0C, 1'b0},
    {4'h4, 8'h3C, 8'h0F, 8'h3F, 1'b0}, {4'h5, 8'h3C, 8'h0F, 8'h33, 1'b0},
    {4'h6, 8'h3A, 8'h43, 8'h25, 1'b1}, {4'h7, 8'h37, 8'h25, 8'h23, 1'b0},
    {4'h8, 8'h37, 8'h25, 8'h06, 1'b0}, {4'h9, 8'h37, 8'h25, 8'h32, 1'b0},
    {4'hA, 8'h37, 8'h25, 8'h75, 1'b0}, {4'hB, 8'h37, 8'h25, 8'h35, 1'b0},
    {4'hC, 8'h37, 8'h25, 8'h72, 1'b0}, {4'hD, 8'h37, 8'h25, 8'h37, 1'b0}};

  cdp_datapath #(.SLICE_CYCLES(200)) i_cdp_datapath (.clk_i, .rst_i,
    .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .halt_key_i, .data_parity_error_flag_i,
    .parity_trap_request_o, .cm_rdata_hi_i, .cm_wdata_hi_o, .io_addr_o,
    .io_out_data_o, .device_select_strobe_o, .outbound_data_strobe_o,
    .input_request_strobe_o, .io_in_data_i, .inbound_data_strobe_i);
  cdp_periph_model i_cdp_periph_model (.clk_i, .wait_i(model_wait),
    .io_addr_i(io_addr_o), .io_out_data_i(io_out_data_o),
    .obs_i(outbound_data_strobe_o), .irs_i(input_request_strobe_o),
    .io_in_data_o(io_in_data_i), .ibs_o(inbound_data_strobe_i), .got_o(got));

  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  task automatic summarize;
    $display("comparisons %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic cmp(input string what, input logic [31:0] exp,
                     input logic [31:0] seen);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Bounded wait for ack; the request stands untouched until then
  task automatic bus(input logic we, input logic [7:0] adr,
                     input logic [31:0] d);
    int k;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= d;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 40);
    if (wb_ack_o !== 1'b1) begin
      cmp("bus ack", 32'h1, 32'h0);
      summarize();
    end
    rdat = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic rc(input logic [7:0] adr, input logic [31:0] m,
                    input logic [31:0] exp, input string what);
    bus(1'b0, adr, 32'h0);
    cmp(what, exp, rdat & m);
  endtask

  task automatic op(input logic [3:0] fn, input logic [3:0] a,
                    input logic [3:0] b, input logic [3:0] d,
                    input logic [7:0] imm);
    bus(1'b1, `CDP_OFF_OP, {8'h00, imm, d, b, a, fn});
  endtask

  initial begin
    repeat (100000) @(posedge clk_i);
    cmp("run length", 32'h1, 32'h0);
    summarize();
  end

  initial begin
    rst_i = 1'b1;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'hF;
    wb_dat_i = 32'h0;
    halt_key_i = 1'b0;
    data_parity_error_flag_i = 1'b0;
    cm_rdata_hi_i = 8'h00;
    model_wait = 4'h0;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 14; i++) begin
      r = rows[i];
      op(`CDP_FN_PASSA, `CDP_SRC_IMM, 4'h0, 4'h1, r[24:17]);
      op(`CDP_FN_PASSA, `CDP_SRC_IMM, 4'h0, 4'h2, r[16:9]);
      op(r[28:25], 4'h1, 4'h2, 4'h7, 8'h00);
      rc(`CDP_OFF_RES, 32'hFF, 32'(r[8:1]), "result");
      if (r[28:25] < 4'h3 || r[28:25] == 4'h6)
        rc(`CDP_OFF_HSR, 32'h1, 32'(r[0]), "carry");
      op(`CDP_FN_PASSA, 4'h7, 4'h0, `CDP_SRC_DUMMY, 8'h00);
      rc(`CDP_OFF_RES, 32'hFF, 32'(r[8:1]), "scratch");
    end
    // Immediate on B reads as zero; a dummy destination keeps nothing
    op(`CDP_FN_ADD, `CDP_SRC_IMM, `CDP_SRC_IMM, `CDP_SRC_DUMMY, 8'h11);
    rc(`CDP_OFF_RES, 32'hFF, 32'h11, "immediate");
    op(`CDP_FN_PASSA, `CDP_SRC_DUMMY, 4'h0, 4'h7, 8'h00);
    rc(`CDP_OFF_RES, 32'hFF, 32'h0, "dummy");
    bus(1'b1, `CDP_OFF_LSR, 32'hA5);
    halt_key_i <= 1'b1;
    data_parity_error_flag_i <= 1'b1;
    repeat (5) @(posedge clk_i);
    rc(`CDP_OFF_LSR, 32'hFF, 32'hA5, "low status");
    rc(`CDP_OFF_HSR, 32'h60, 32'h60, "halt and parity");
    cmp("trap off", 32'h0, 32'(parity_trap_request_o));
    bus(1'b1, `CDP_OFF_HSR, 32'h80);
    repeat (4) @(posedge clk_i);
    cmp("trap on", 32'h1, 32'(parity_trap_request_o));
    halt_key_i <= 1'b0;
    data_parity_error_flag_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    bus(1'b1, `CDP_OFF_HSR, 32'h0);
    rc(`CDP_OFF_HSR, 32'h60, 32'h0, "halt cleared");
    cmp("trap cleared", 32'h0, 32'(parity_trap_request_o));
    op(`CDP_FN_PASSA, `CDP_SRC_IMM, 4'h0, `CDP_SRC_LSR, 8'h3C);
    rc(`CDP_OFF_LSR, 32'hFF, 32'h3C, "low status alu");
    op(`CDP_FN_PASSA, `CDP_SRC_LSR, 4'h0, `CDP_SRC_ACC, 8'h00);
    rc(`CDP_OFF_ACC, 32'hFF, 32'h3C, "alu to accumulator");
    bus(1'b1, `CDP_OFF_ACC, 32'h3C);
    bus(1'b1, `CDP_OFF_IOC, 32'h8);
    rc(`CDP_OFF_DSL, 32'hFF, 32'h3C, "select latch");
    bus(1'b1, `CDP_OFF_ACC, 32'h99);
    bus(1'b1, `CDP_OFF_IOC, 32'h3);
    cmp("address bus", 32'h3C, 32'(io_addr_o));
    cmp("sent data", 32'h99, 32'(got));
    for (int w = 0; w < 16; w += 15) begin
      model_wait <= 4'(w);
      bus(1'b1, `CDP_OFF_ACC, 32'h0);
      bus(1'b1, `CDP_OFF_IOC, 32'h4);
      n = 0;
      do begin
        bus(1'b0, `CDP_OFF_ACC, 32'h0);
        n++;
      end while (rdat[7:0] !== 8'h66 && n < 20);
      cmp("inbound", 32'h66, rdat & 32'hFF);
    end
    bus(1'b1, `CDP_OFF_ACC, 32'h0);
    bus(1'b1, `CDP_OFF_IOC, 32'h10);
    rc(`CDP_OFF_ACC, 32'hFF, 32'h66, "source input");
    op(`CDP_FN_PASSA, `CDP_SRC_IMM, 4'h0, `CDP_SRC_DUMMY, 8'h5D);
    bus(1'b1, `CDP_OFF_IOC, 32'h20);
    rc(`CDP_OFF_ACC, 32'hFF, 32'h5D, "source c bus");
    cm_rdata_hi_i <= 8'hC3;
    bus(1'b1, `CDP_OFF_IOC, 32'h30);
    rc(`CDP_OFF_ACC, 32'hFF, 32'hC3, "source control");
    cmp("control byte", 32'hC3, 32'(cm_wdata_hi_o));
    bus(1'b1, `CDP_OFF_FPTR, 32'h1234);
    bus(1'b1, `CDP_OFF_STK, 32'h0100_0001);
    bus(1'b1, `CDP_OFF_STK, 32'h0200_0001);
    rc(`CDP_OFF_FPTR, 32'hFFFF, 32'h0200, "call");
    bus(1'b1, `CDP_OFF_STK, 32'h2);
    rc(`CDP_OFF_FPTR, 32'hFFFF, 32'h0101, "return");
    bus(1'b1, `CDP_OFF_STK, 32'h2);
    rc(`CDP_OFF_FPTR, 32'hFFFF, 32'h1235, "return");
    bus(1'b1, `CDP_OFF_STK, 32'h2);
    rc(`CDP_OFF_STK, 32'h8000, 32'h8000, "underflow");
    for (int i = 0; i < 97; i++)
      bus(1'b1, `CDP_OFF_STK, 32'h0001_0001);
    rc(`CDP_OFF_STK, 32'hFF00, 32'hE000, "overflow");
    bus(1'b1, `CDP_OFF_STK, 32'h2);
    rc(`CDP_OFF_FPTR, 32'hFFFF, 32'h0002, "deep pop");
    bus(1'b1, `CDP_OFF_AUXSEL, 32'h1F);
    bus(1'b1, `CDP_OFF_AUXDAT, 32'hBEEF);
    bus(1'b1, `CDP_OFF_AUXSEL, 32'h0);
    bus(1'b1, `CDP_OFF_AUXDAT, 32'h1111);
    bus(1'b1, `CDP_OFF_AUXSEL, 32'h1F);
    rc(`CDP_OFF_AUXDAT, 32'hFFFF, 32'hBEEF, "aux");
    bus(1'b1, 8'hFC, 32'hFF);
    rc(8'hFC, 32'hFFFF_FFFF, 32'h0, "unmapped");
    rc(`CDP_OFF_LSR, 32'hFF, 32'h3C, "low status kept");
    // Slice bit must survive until software clears it; clearing first
    // lines the later checks up with the timer phase
    bus(1'b1, `CDP_OFF_HSR, 32'h0);
    n = 0;
    do begin
      bus(1'b0, `CDP_OFF_HSR, 32'h0);
      n++;
    end while (rdat[4] !== 1'b1 && n < 100);
    cmp("slice", 32'h10, rdat & 32'h10);
    repeat (60) @(posedge clk_i);
    rc(`CDP_OFF_HSR, 32'h10, 32'h10, "slice held");
    bus(1'b1, `CDP_OFF_HSR, 32'h0);
    rc(`CDP_OFF_HSR, 32'h10, 32'h0, "slice cleared");
    repeat (100) @(posedge clk_i);
    rc(`CDP_OFF_HSR, 32'h10, 32'h0, "slice early");
    repeat (40) @(posedge clk_i);
    rc(`CDP_OFF_HSR, 32'h10, 32'h10, "slice again");
    rst_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    rc(`CDP_OFF_HSR, 32'hFF, 32'h0, "reset high status");
    rc(`CDP_OFF_LSR, 32'hFF, 32'h0, "reset low status");
    rc(`CDP_OFF_ACC, 32'hFF, 32'h0, "reset accumulator");
    rc(`CDP_OFF_DSL, 32'hFF, 32'h0, "reset latch");
    rc(`CDP_OFF_STK, 32'hFFFF, 32'h0, "reset stack");
    summarize();
  end
endmodule
